// ==== shared/fec_ctc_pkg.sv ====
package fec_ctc_pkg;

  // ********************************
  // bus geometry
  // ********************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************
  // register indices, byte address is index times four
  // ********************************
  localparam logic [15:0] IDX_CORR_LOW = 16'h00ac;
  localparam logic [15:0] IDX_CORR_HIGH = 16'h00ad;
  localparam logic [15:0] IDX_UNCORR_LOW = 16'h00ae;
  localparam logic [15:0] IDX_UNCORR_HIGH = 16'h00af;
  localparam logic [15:0] IDX_COMP_CONTROL = 16'h8001;
  localparam logic [15:0] IDX_COMP_STATUS = 16'h8010;

  // ********************************
  // compensation_fifo_control fields
  // ********************************
  localparam logic [15:0] COMP_CONTROL_RESET = 16'hcc4c;
  localparam int DEPTH_SEL_LSB = 12;
  localparam int WMK_SEL_LSB = 10;
  localparam int Q_DROP_BIT = 8;
  localparam logic [2:0] DEPTH_SEL_24 = 3'h3;
  localparam logic [2:0] DEPTH_SEL_16 = 3'h2;
  localparam logic [2:0] DEPTH_SEL_12 = 3'h1;
  localparam logic [2:0] DEPTH_SEL_8 = 3'h0;

  // ********************************
  // watermark levels, as fill of the staging fifo
  // ********************************
  localparam logic [1:0] WMK_LOW = 2'h0;
  localparam logic [1:0] WMK_MID = 2'h1;
  localparam logic [1:0] WMK_MID_HIGH = 2'h2;
  localparam logic [1:0] WMK_HIGH = 2'h3;

  // ********************************
  // compensation status fields
  // ********************************
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_DROPS_LSB = 8;

  // ********************************
  // datapath
  // ********************************
  localparam int STREAM_W = 32;
  localparam int FIFO_DEPTH = 4;

endpackage : fec_ctc_pkg

// ==== verilog/stream_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [CNT_W-1:0] count
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage has no reset, it is qualified by count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : stream_fifo
`default_nettype wire

// ==== verilog/split_block_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module split_block_counter #(
  parameter int HALF_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // event and read strobes
  input wire logic event_pulse,
  input wire logic read_low,
  input wire logic read_high,
  // halves as they read now
  output logic [HALF_W-1:0] low_value,
  output logic [HALF_W-1:0] high_value
);
  logic [2*HALF_W-1:0] total;
  logic [HALF_W-1:0] held_high;
  logic held_valid;
  wire at_max = &total;
  // saturate rather than wrap, a wrapped count would look like few errors
  wire [2*HALF_W-1:0] bumped = total + (2*HALF_W)'(event_pulse & ~at_max);
  wire [2*HALF_W-1:0] one_if_event = (2*HALF_W)'(event_pulse);

  assign low_value = total[HALF_W-1:0];
  assign high_value = held_valid ? held_high : total[2*HALF_W-1:HALF_W];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      total <= '0;
      held_high <= '0;
      held_valid <= 1'b0;
    end else if (read_low) begin
      // whole count leaves; an event in this cycle survives as one
      held_high <= total[2*HALF_W-1:HALF_W];
      held_valid <= 1'b1;
      total <= one_if_event;
    end else if (read_high && held_valid) begin
      held_valid <= 1'b0;
      held_high <= '0;
      total <= bumped;
    end else if (read_high) begin
      total <= {{HALF_W{1'b0}}, total[HALF_W-1:0]} + one_if_event;
    end else begin
      total <= bumped;
    end
  end

endmodule : split_block_counter
`default_nettype wire

// ==== verilog/fec_ctc_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// - corrected high half at 0xAD, clears on read
// - uncorrectable halves at 0xAE/0xAF, clear on read
// - 3-bit depth select, 000 disables compensation
// - q column drop only when enable set
// - corrected low half at 0xAC, clears on read
module fec_ctc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fec_ctc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [fec_ctc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [fec_ctc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [fec_ctc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // fec decoder events, one per block
  input wire logic corrected_block_event,
  input wire logic uncorrectable_block_event,
  // receive stream in
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [fec_ctc_pkg::STREAM_W-1:0] rx_in_data,
  input wire logic rx_in_q_column,
  // receive stream out
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic [fec_ctc_pkg::STREAM_W-1:0] rx_out_data,
  // compensation settings toward the channel
  output logic [2:0] rx_comp_depth_select,
  output logic [1:0] rx_comp_watermark_select,
  output logic rx_q_column_drop_enable
);
  localparam int CNT_W = $clog2(fec_ctc_pkg::FIFO_DEPTH + 1);
  localparam int AW = fec_ctc_pkg::ADDR_W;

  // ********************************
  // byte addresses
  // ********************************
  localparam logic [AW-1:0] ADDR_CORR_LOW = AW'(fec_ctc_pkg::IDX_CORR_LOW) << 2;
  localparam logic [AW-1:0] ADDR_CORR_HIGH = AW'(fec_ctc_pkg::IDX_CORR_HIGH) << 2;
  localparam logic [AW-1:0] ADDR_UNCORR_LOW = AW'(fec_ctc_pkg::IDX_UNCORR_LOW) << 2;
  localparam logic [AW-1:0] ADDR_UNCORR_HIGH = AW'(fec_ctc_pkg::IDX_UNCORR_HIGH) << 2;
  localparam logic [AW-1:0] ADDR_CONTROL = AW'(fec_ctc_pkg::IDX_COMP_CONTROL) << 2;
  localparam logic [AW-1:0] ADDR_STATUS = AW'(fec_ctc_pkg::IDX_COMP_STATUS) << 2;

  // ********************************
  // write channel
  // ********************************
  logic aw_held;
  logic w_held;
  logic [AW-1:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic [15:0] comp_control;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  // a write lands once both halves are held and the last response is gone
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire next_aw_held = ~wr_fire & (aw_held | aw_take);
  wire next_w_held = ~wr_fire & (w_held | w_take);
  wire next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  wire wr_hit_control = (wr_addr == ADDR_CONTROL);
  // counters are read-only, writes to them are accepted and dropped
  wire wr_hit_ro = (wr_addr == ADDR_CORR_LOW) | (wr_addr == ADDR_CORR_HIGH)
                 | (wr_addr == ADDR_UNCORR_LOW) | (wr_addr == ADDR_UNCORR_HIGH)
                 | (wr_addr == ADDR_STATUS);
  wire wr_mapped = wr_hit_control | wr_hit_ro;
  wire [15:0] strb_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [15:0] next_comp_control = (wr_fire & wr_hit_control)
                                ? ((comp_control & ~strb_mask) | (wr_data & strb_mask))
                                : comp_control;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fec_ctc_pkg::RESP_OKAY;
      comp_control <= fec_ctc_pkg::COMP_CONTROL_RESET;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata[15:0];
        wr_strb <= s_axi_wstrb[1:0];
      end
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= wr_mapped ? fec_ctc_pkg::RESP_OKAY : fec_ctc_pkg::RESP_SLVERR;
      end
      comp_control <= next_comp_control;
    end
  end

  // ********************************
  // compensation settings
  // ********************************
  wire [2:0] depth_sel = comp_control[fec_ctc_pkg::DEPTH_SEL_LSB +: 3];
  wire [1:0] wmk_sel = comp_control[fec_ctc_pkg::WMK_SEL_LSB +: 2];
  wire q_drop_en = comp_control[fec_ctc_pkg::Q_DROP_BIT];
  // depth 000 turns compensation off whatever the other fields hold
  wire comp_enabled = (depth_sel != fec_ctc_pkg::DEPTH_SEL_8);
  wire depth_32 = depth_sel[2];

  assign rx_comp_depth_select = comp_control[fec_ctc_pkg::DEPTH_SEL_LSB +: 3];
  assign rx_comp_watermark_select = comp_control[fec_ctc_pkg::WMK_SEL_LSB +: 2];
  assign rx_q_column_drop_enable = comp_control[fec_ctc_pkg::Q_DROP_BIT];

  // depths of 12 and below have no choice of threshold
  wire [1:0] level_32 = wmk_sel;
  wire [1:0] level_24 = (wmk_sel == 2'h3) ? fec_ctc_pkg::WMK_HIGH
                      : (wmk_sel == 2'h2) ? fec_ctc_pkg::WMK_MID
                      : fec_ctc_pkg::WMK_LOW;
  wire [1:0] level_16 = wmk_sel[1] ? fec_ctc_pkg::WMK_HIGH : fec_ctc_pkg::WMK_LOW;
  wire [1:0] wmk_level = depth_32 ? level_32
                       : (depth_sel == fec_ctc_pkg::DEPTH_SEL_24) ? level_24
                       : (depth_sel == fec_ctc_pkg::DEPTH_SEL_16) ? level_16
                       : fec_ctc_pkg::WMK_HIGH;
  // level n means the staging fifo holds more than n words
  wire [CNT_W-1:0] wmk_fill = CNT_W'(wmk_level) + CNT_W'(1);

  // ********************************
  // receive path with q column drop
  // ********************************
  logic hold_valid;
  logic hold_q;
  logic [fec_ctc_pkg::STREAM_W-1:0] hold_data;
  logic [7:0] drop_count;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [fec_ctc_pkg::STREAM_W-1:0] fifo_out_data;
  logic [CNT_W-1:0] fifo_count;

  wire in_take = rx_in_valid & rx_in_ready;
  // a q column goes only once the staging fifo has reached the mark;
  // below it every word is kept so the output does not run dry
  wire drop_hold = hold_valid & hold_q & q_drop_en & comp_enabled
                 & (fifo_count >= wmk_fill);
  wire fifo_push = hold_valid & ~drop_hold;
  wire hold_leaves = drop_hold | (fifo_push & fifo_in_ready);
  wire next_hold_valid = in_take | (hold_valid & ~hold_leaves);
  // output stage refills as soon as it empties or drains
  wire out_load = ~rx_out_valid | rx_out_ready;
  wire fifo_pop = fifo_out_valid & out_load;

  // only the hold stage fills the staging fifo
  stream_fifo #(
    .WIDTH(fec_ctc_pkg::STREAM_W),
    .DEPTH(fec_ctc_pkg::FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_staging (
    .clk(clk),
    .resetn(resetn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(hold_data),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // ready is a flop, so the hold stage accepts every other cycle at most
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_valid <= 1'b0;
      hold_q <= 1'b0;
      hold_data <= '0;
      rx_in_ready <= 1'b1;
      rx_out_valid <= 1'b0;
      rx_out_data <= '0;
      drop_count <= '0;
    end else begin
      hold_valid <= next_hold_valid;
      rx_in_ready <= ~next_hold_valid;
      if (in_take) begin
        hold_data <= rx_in_data;
        hold_q <= rx_in_q_column;
      end
      if (out_load) begin
        rx_out_valid <= fifo_out_valid;
      end
      if (fifo_pop) begin
        rx_out_data <= fifo_out_data;
      end
      if (drop_hold && drop_count != 8'hff) begin
        drop_count <= drop_count + 8'h01;
      end
    end
  end

  // ********************************
  // statistics counters
  // ********************************
  logic [15:0] corr_low;
  logic [15:0] corr_high;
  logic [15:0] uncorr_low;
  logic [15:0] uncorr_high;

  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_corr_low = (s_axi_araddr == ADDR_CORR_LOW);
  wire rd_corr_high = (s_axi_araddr == ADDR_CORR_HIGH);
  wire rd_uncorr_low = (s_axi_araddr == ADDR_UNCORR_LOW);
  wire rd_uncorr_high = (s_axi_araddr == ADDR_UNCORR_HIGH);
  wire rd_control = (s_axi_araddr == ADDR_CONTROL);
  wire rd_status = (s_axi_araddr == ADDR_STATUS);
  wire rd_mapped = rd_corr_low | rd_corr_high | rd_uncorr_low | rd_uncorr_high
                 | rd_control | rd_status;

  // each counter sets its high half aside once the low half is read
  split_block_counter #(
    .HALF_W(fec_ctc_pkg::REG_W)
  ) u_corrected (
    .clk(clk),
    .resetn(resetn),
    .event_pulse(corrected_block_event),
    .read_low(ar_take & rd_corr_low),
    .read_high(ar_take & rd_corr_high),
    .low_value(corr_low),
    .high_value(corr_high)
  );

  split_block_counter #(
    .HALF_W(fec_ctc_pkg::REG_W)
  ) u_uncorrectable (
    .clk(clk),
    .resetn(resetn),
    .event_pulse(uncorrectable_block_event),
    .read_low(ar_take & rd_uncorr_low),
    .read_high(ar_take & rd_uncorr_high),
    .low_value(uncorr_low),
    .high_value(uncorr_high)
  );

  // ********************************
  // read channel
  // ********************************
  // status fields at their package positions, gaps read as zero
  wire [15:0] status_word = (16'(drop_count) << fec_ctc_pkg::STAT_DROPS_LSB)
                          | (16'(wmk_level) << fec_ctc_pkg::STAT_LEVEL_LSB)
                          | 16'(fifo_count);
  wire [15:0] rd_word = rd_corr_low ? corr_low
                      : rd_corr_high ? corr_high
                      : rd_uncorr_low ? uncorr_low
                      : rd_uncorr_high ? uncorr_high
                      : rd_control ? comp_control
                      : rd_status ? status_word
                      : 16'h0000;
  // counters clear at the address handshake, so a refused read loses nothing
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= fec_ctc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_mapped ? fec_ctc_pkg::RESP_OKAY : fec_ctc_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : fec_ctc_regs
`default_nettype wire

// ==== tb/fec_ctc_regs_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module fec_ctc_regs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [19:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // stream
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic rx_out_valid,
  input wire logic rx_out_ready,
  input wire logic [31:0] rx_out_data,
  // settings
  input wire logic [2:0] rx_comp_depth_select,
  input wire logic [1:0] rx_comp_watermark_select,
  input wire logic rx_q_column_drop_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [5:0] ctrl = {rx_comp_depth_select, rx_comp_watermark_select, rx_q_column_drop_enable};
  // ********************************
  // settings
  // ********************************
  chk_ctrl_reset: assert property ($rose(resetn) |-> ctrl == 6'h26)
    else $error("settings not at reset value");
  // settings may only move with a write response
  chk_ctrl_moves: assert property (!$stable(ctrl) |-> $rose(s_axi_bvalid))
    else $error("settings moved without a write");
  // ********************************
  // register bus
  // ********************************
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_unaligned_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == fec_ctc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unaligned read not refused");
  chk_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // ********************************
  // stream
  // ********************************
  chk_in_gap: assert property (rx_in_valid && rx_in_ready |=> !rx_in_ready)
    else $error("stream input taken twice in a row");
  chk_out_hold: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out_data))
    else $error("stream output changed while stalled");
endmodule : fec_ctc_regs_asserts
bind fec_ctc_regs fec_ctc_regs_asserts chk (
  .clk, .resetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .rx_in_valid, .rx_in_ready, .rx_out_valid,
  .rx_out_ready, .rx_out_data, .rx_comp_depth_select, .rx_comp_watermark_select,
  .rx_q_column_drop_enable
);
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // write side
  output logic awvalid,
  input wire logic awready,
  output logic [19:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  // read side
  output logic arvalid,
  input wire logic arready,
  output logic [19:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 72'h0;
    {awprot, arprot, wstrb} = 10'h000;
  end
  task wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
    fork
      begin do @(posedge clk); while (!awready); awvalid <= 1'b0; awaddr <= ~a; end
      begin do @(posedge clk); while (!wready); wvalid <= 1'b0; wdata <= ~d; end
    join
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [19:0] a);
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0; araddr <= ~a;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  // low half first so the high half comes from the same count
  task rd_count(input logic [15:0] lo);
    rd({2'b00, lo, 2'b00});
    rd({2'b00, lo + 16'h0001, 2'b00});
  endtask : rd_count
endmodule : host_model
`default_nettype wire

// ==== tb/fec_ctc_regs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module fec_ctc_regs_tb_top;
  typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} rexp_t;
  logic clk = 0, resetn = 0, stall = 0, corrected_block_event, uncorrectable_block_event;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_in_valid, rx_in_ready;
  logic rx_in_q_column, rx_out_valid, rx_out_ready, rx_q_column_drop_enable;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx_in_data, rx_out_data;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot, rx_comp_depth_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_comp_watermark_select;
  logic [15:0] rng = 16'h002f, v;
  int failures = 0, checked = 0;
  rexp_t rq[$];
  logic [1:0] bq[$];
  logic [31:0] sq[$];
  localparam logic [31:0] ALL = 32'hffff_ffff;
  fec_ctc_regs dut (.clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .corrected_block_event, .uncorrectable_block_event,
    .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_in_q_column, .rx_out_valid, .rx_out_ready,
    .rx_out_data, .rx_comp_depth_select, .rx_comp_watermark_select, .rx_q_column_drop_enable);
  host_model host (.clk, .awvalid(s_axi_awvalid), .awready(s_axi_awready), .awaddr(s_axi_awaddr),
    .awprot(s_axi_awprot), .wvalid(s_axi_wvalid), .wready(s_axi_wready), .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb), .bvalid(s_axi_bvalid), .bready(s_axi_bready), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .araddr(s_axi_araddr), .arprot(s_axi_arprot),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));
  // ********************************
  // helpers
  // ********************************
  always #20 clk = ~clk;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function logic [19:0] ad(input logic [15:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad
  function logic [1:0] lvl(input logic [2:0] d, input logic [1:0] w);
    if (d[2]) return w;
    if (d == 3'h3) return (w == 2'h3) ? 2'h3 : ((w == 2'h2) ? 2'h1 : 2'h0);
    if (d == 3'h2) return w[1] ? 2'h3 : 2'h0;
    return 2'h3;
  endfunction : lvl
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk_val
  task chk_rd(input rexp_t e);
    chk_val(s_axi_rdata & e.mask, e.data & e.mask);
    chk_val({30'h0, s_axi_rresp}, {30'h0, e.resp});
  endtask : chk_rd
  task ex(input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{r, d, m});
  endtask : ex
  task br(input logic [19:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    ex(d, m, r);
    host.rd(a);
  endtask : br
  task bw(input logic [19:0] a, input logic [15:0] d, input logic [1:0] r);
    bq.push_back(r);
    host.wr(a, {16'h0000, d});
  endtask : bw
  task pulses(input logic c, input logic u, input int n);
    repeat (n) begin
      @(posedge clk);
      corrected_block_event <= c;
      uncorrectable_block_event <= u;
    end
    @(posedge clk);
    {corrected_block_event, uncorrectable_block_event} <= 2'b00;
  endtask : pulses
  task send(input logic q, input logic keep);
    @(posedge clk);
    if (keep) sq.push_back({rng, ~rng});
    rx_in_valid <= 1'b1; rx_in_data <= {rng, ~rng}; rx_in_q_column <= q;
    do @(posedge clk); while (!rx_in_ready);
    rx_in_valid <= 1'b0; rx_in_data <= {~rng, rng};
  endtask : send
  task drain;
    for (int k = 0; k < 300 && sq.size() != 0; k++) @(posedge clk);
    chk_val(sq.size(), 32'h0);
  endtask : drain
  task close_out;
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // ********************************
  // monitor and far-side stall
  // ********************************
  always @(posedge clk) begin
    rng <= lfsr(rng);
    rx_out_ready <= !stall && rng[2];
    if (s_axi_rvalid && s_axi_rready) chk_rd(rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk_val({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (rx_out_valid && rx_out_ready) chk_val(rx_out_data, sq.pop_front());
  end
  initial begin
    #4_000_000;
    failures++;
    close_out;
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    {rx_in_valid, rx_in_q_column} = 2'h0;
    {corrected_block_event, uncorrectable_block_event, rx_in_data} = 34'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    br(ad(fec_ctc_pkg::IDX_COMP_CONTROL), 32'h0000_cc4c, ALL, fec_ctc_pkg::RESP_OKAY);
    for (int d = 0; d < 5; d++) for (int w = 0; w < 4; w++) begin
      v = {1'b1, 3'(d), 2'(w), 10'h04c};
      bw(ad(fec_ctc_pkg::IDX_COMP_CONTROL), v, fec_ctc_pkg::RESP_OKAY);
      br(ad(fec_ctc_pkg::IDX_COMP_CONTROL), {16'h0, v}, ALL, fec_ctc_pkg::RESP_OKAY);
      chk_val({26'h0, rx_comp_depth_select, rx_comp_watermark_select, rx_q_column_drop_enable},
        {26'h0, v[14:10], 1'b0});
      br(ad(fec_ctc_pkg::IDX_COMP_STATUS), {26'h0, lvl(v[14:12], v[11:10]), 4'h0}, 32'h0000_0030,
        fec_ctc_pkg::RESP_OKAY);
    end
    bw(20'h0_0100, 16'h1234, fec_ctc_pkg::RESP_SLVERR);
    bw(ad(fec_ctc_pkg::IDX_CORR_LOW), 16'hffff, fec_ctc_pkg::RESP_OKAY);
    br(20'h0_02b1, 32'h0, ALL, fec_ctc_pkg::RESP_SLVERR);
    br(20'h0_0100, 32'h0, ALL, fec_ctc_pkg::RESP_SLVERR);
    // counters past the half boundary
    pulses(1'b1, 1'b1, 65538);
    br(ad(fec_ctc_pkg::IDX_CORR_HIGH), 32'h1, ALL, fec_ctc_pkg::RESP_OKAY);
    br(ad(fec_ctc_pkg::IDX_CORR_HIGH), 32'h0, ALL, fec_ctc_pkg::RESP_OKAY);
    br(ad(fec_ctc_pkg::IDX_CORR_LOW), 32'h2, ALL, fec_ctc_pkg::RESP_OKAY);
    br(ad(fec_ctc_pkg::IDX_UNCORR_LOW), 32'h2, ALL, fec_ctc_pkg::RESP_OKAY);
    pulses(1'b0, 1'b1, 3);
    br(ad(fec_ctc_pkg::IDX_UNCORR_HIGH), 32'h1, ALL, fec_ctc_pkg::RESP_OKAY);
    br(ad(fec_ctc_pkg::IDX_UNCORR_LOW), 32'h3, ALL, fec_ctc_pkg::RESP_OKAY);
    br(ad(fec_ctc_pkg::IDX_UNCORR_HIGH), 32'h0, ALL, fec_ctc_pkg::RESP_OKAY);
    v = {12'h000, rng[3:0]} + 16'h0001;
    pulses(1'b1, 1'b0, int'(v));
    ex({16'h0, v}, ALL, fec_ctc_pkg::RESP_OKAY);
    ex(32'h0, ALL, fec_ctc_pkg::RESP_OKAY);
    host.rd_count(fec_ctc_pkg::IDX_CORR_LOW);
    // stream, q columns pass while dropping is off
    for (int i = 0; i < 12; i++) send(rng[0], 1'b1);
    drain;
    bw(ad(fec_ctc_pkg::IDX_COMP_CONTROL), 16'hc14c, fec_ctc_pkg::RESP_OKAY);
    stall <= 1'b1;
    @(posedge clk);
    repeat (3) send(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    send(1'b1, 1'b0);
    repeat (2) send(1'b0, 1'b1);
    fork
      send(1'b0, 1'b1);
      begin
        repeat (6) @(posedge clk);
        chk_val({31'h0, rx_in_ready}, 32'h0);
        stall <= 1'b0;
      end
    join
    drain;
    // compensation off: a q column waits for room, never dropped
    bw(ad(fec_ctc_pkg::IDX_COMP_CONTROL), 16'h814c, fec_ctc_pkg::RESP_OKAY);
    stall <= 1'b1;
    repeat (5) send(1'b0, 1'b1);
    fork
      send(1'b1, 1'b1);
      begin
        repeat (8) @(posedge clk);
        stall <= 1'b0;
      end
    join
    drain;
    br(ad(fec_ctc_pkg::IDX_COMP_STATUS), 32'h0000_0130, 32'h0000_ff37,
      fec_ctc_pkg::RESP_OKAY);
    close_out;
  end
endmodule : fec_ctc_regs_tb_top
`default_nettype wire
